// file: common/usb_ctl_consts.svh
`ifndef USB_CTL_CONSTS_SVH
`define USB_CTL_CONSTS_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define CTL_REG_OFFSET   32'h0000_0000
`define CTL_RESET_VALUE  8'h00

// ----------------------------------------------------------------
// Field positions of the control and status word
// ----------------------------------------------------------------
`define BIT_LIVE_J       7
`define BIT_LIVE_SE0     6
`define BIT_PKT_TOK      5
`define BIT_BUS_RST      4
`define BIT_HOST_EN      3
`define BIT_RESUME       2
`define BIT_PPB_RST      1
`define BIT_USB_EN       0

// ----------------------------------------------------------------
// AXI4-Lite responses
// ----------------------------------------------------------------
`define RESP_OKAY        2'b00
`define RESP_SLVERR      2'b10

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS    4
`define LS_EOP_TIME_NS   1333
`define LS_EOP_CYCLES    ((`LS_EOP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define EOP_CNT_W        9

`endif

// file: common/usb_ctl_pkg.sv
`include "usb_ctl_consts.svh"

package usb_ctl_pkg;

   // Resume engine states, one-hot
   typedef enum logic [2:0] {
      RES_IDLE  = 3'b001,
      RES_DRIVE = 3'b010,
      RES_EOP   = 3'b100
   } resume_fsm_type;

   // Resume engine state
   typedef struct packed {
      resume_fsm_type             fsm;
      logic [`EOP_CNT_W-1:0]      count;
   } resume_state_type;

   // Register block and bus slave state
   typedef struct packed {
      logic        aw_have;
      logic        aw_hit;
      logic        w_have;
      logic [7:0]  w_data;
      logic        w_lane0;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [1:0]  rresp;
      logic [31:0] rdata;
      logic        pkt_dis;
      logic        bus_rst;
      logic        host_en;
      logic        resume_en;
      logic        ppb_rst;
      logic        usb_en;
   } ctl_state_type;

endpackage

// file: common/resume_if.sv
`timescale 1ns/10ps
`default_nettype none

// Control of the resume engine
interface resume_if;
   logic resume_en;
   logic host_mode;
   logic abort;
   logic resume_drive;
   logic eop_drive;

   modport ctl (output resume_en, output host_mode, output abort, input resume_drive, input eop_drive);
   modport eng (input resume_en, input host_mode, input abort, output resume_drive, output eop_drive);
endinterface

`default_nettype wire

// file: src/change_detect.sv
`timescale 1ns/10ps
`default_nettype none

// Pulses for one cycle whenever its input changes value
module change_detect #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         aclk,
   input  wire logic         aresetn,
   // Watched level and change pulse
   input  wire logic [W-1:0] level,
   output logic              changed
);
   import usb_ctl_pkg::*;

   typedef struct packed {
      logic [W-1:0] prev;
   } change_state_type;

   change_state_type q;
   change_state_type d;

   // Remember previous value
   always_comb begin
      d      = q;
      d.prev = level;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign changed = (level != q.prev);
endmodule

`default_nettype wire

// file: src/resume_engine.sv
`timescale 1ns/10ps
`default_nettype none
`include "usb_ctl_consts.svh"

// Drives resume signalling and the closing low-speed EOP
module resume_engine #(
   parameter int EOP_CYCLES = `LS_EOP_CYCLES
) (
   // Clock and reset
   input  wire logic aclk,
   input  wire logic aresetn,
   // Control from the register block
   resume_if.eng     rif
);
   import usb_ctl_pkg::*;

   localparam logic [`EOP_CNT_W-1:0] EOP_LAST = `EOP_CNT_W'(EOP_CYCLES - 1);

   resume_state_type q;
   resume_state_type d;

   // State transitions
   always_comb begin
      d = q;
      unique case (q.fsm)
         RES_IDLE: begin
            if (rif.resume_en) begin
               d.fsm = RES_DRIVE; // R9
            end
         end
         RES_DRIVE: begin
            if (!rif.resume_en) begin
               d.count = '0;
               d.fsm   = rif.host_mode ? RES_EOP : RES_IDLE; // R11
            end
         end
         RES_EOP: begin
            if (rif.resume_en) begin
               d.fsm = RES_DRIVE;
            end else if (q.count == EOP_LAST) begin
               d.fsm = RES_IDLE;
            end else begin
               d.count = q.count + `EOP_CNT_W'(1);
            end
         end
      endcase
      // Host logic reset aborts signalling
      if (rif.abort) begin
         d.fsm   = RES_IDLE; // R8
         d.count = '0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= '{fsm: RES_IDLE, count: '0};
      end else begin
         q <= d;
      end
   end

   assign rif.resume_drive = (q.fsm == RES_DRIVE);
   assign rif.eop_drive    = (q.fsm == RES_EOP);
endmodule

`default_nettype wire

// file: src/usb_control_register.sv
// Contract
// R1 - Bit 7 reads 1 live while the receiver sees a J state.
// R2 - Bit 6 reads 1 live while a single-ended zero is on the bus.
// R3 - Device mode: bit 5 disables packet processing; SETUP token sets it.
// R4 - Host mode: bit 5 reads 1 while a token is executing.
// R5 - Host software waits for token busy clear before a new token command.
// R6 - Host mode: bit 4 written 1 generates bus reset, 0 ends it.
// R7 - Bit 3 enables host capability when 1, disables when 0.
// R8 - Any change of the host enable bit resets all host control logic.
// R9 - Bit 2 drives resume signalling while 1 and stops it at 0.
// R10 - Software holds resume 10 ms as function, 25 ms as host.
// R11 - Host mode: clearing resume appends a low-speed end-of-packet.
// R12 - Bits 31 to 8 read as zero; writes to them do nothing.
// R13 - Device software clears packet disable after handling a SETUP.
`timescale 1ns/10ps
`default_nettype none
`include "usb_ctl_consts.svh"

module usb_control_register #(
   parameter int ADDR_W     = 12,
   parameter int EOP_CYCLES = `LS_EOP_CYCLES
) (
   // Clock and reset
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // AXI4-Lite write address
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic [2:0]        s_axi_awprot,
   // AXI4-Lite write data
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   // AXI4-Lite write response
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   output logic [1:0]             s_axi_bresp,
   // AXI4-Lite read address
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic [2:0]        s_axi_arprot,
   // AXI4-Lite read data
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   // Line state from the transceiver
   input  wire logic              rx_j_state,
   input  wire logic              rx_se0,
   // Protocol engine status
   input  wire logic              setup_token_rcvd,
   input  wire logic              token_active,
   // Controls to the protocol engine
   output logic                   packet_processing_disable,
   output logic                   host_capability_enable,
   output logic                   host_logic_reset,
   output logic                   bus_reset_generate,
   output logic                   ping_pong_reset,
   output logic                   module_enable,
   // Line signalling requests
   output logic                   resume_drive,
   output logic                   eop_drive
);
   import usb_ctl_pkg::*;

   // ----------------------------------------------------------------
   // Constants and state
   // ----------------------------------------------------------------
   localparam logic [31:0] CTL_OFF = `CTL_REG_OFFSET;

   ctl_state_type q;
   ctl_state_type d;
   logic          aw_fire;
   logic          w_fire;
   logic          ar_fire;
   logic          ar_hit;
   logic          commit;
   logic          host_toggle;
   logic [7:0]    ctl_word;

   resume_if rif ();

   // ----------------------------------------------------------------
   // Bus handshakes
   // ----------------------------------------------------------------

   // Each write channel takes one item, none while a response is pending
   assign s_axi_awready = !q.aw_have && !q.bvalid;
   assign s_axi_wready  = !q.w_have && !q.bvalid;
   assign s_axi_arready = !q.rvalid;

   assign aw_fire = s_axi_awvalid && s_axi_awready;
   assign w_fire  = s_axi_wvalid && s_axi_wready;
   assign ar_fire = s_axi_arvalid && s_axi_arready;
   assign ar_hit  = (s_axi_araddr[ADDR_W-1:2] == CTL_OFF[ADDR_W-1:2]);
   assign commit  = q.aw_have && q.w_have;

   // Live view of the word; upper bits zero
   always_comb begin
      ctl_word                = `CTL_RESET_VALUE;
      ctl_word[`BIT_LIVE_J]   = rx_j_state; // R1
      ctl_word[`BIT_LIVE_SE0] = rx_se0; // R2
      ctl_word[`BIT_PKT_TOK]  = q.host_en ? token_active : q.pkt_dis; // R4
      ctl_word[`BIT_BUS_RST]  = q.bus_rst;
      ctl_word[`BIT_HOST_EN]  = q.host_en;
      ctl_word[`BIT_RESUME]   = q.resume_en;
      ctl_word[`BIT_PPB_RST]  = q.ppb_rst;
      ctl_word[`BIT_USB_EN]   = q.usb_en;
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      d = q;
      // Capture write address and its decode
      if (aw_fire) begin
         d.aw_have = 1'b1;
         d.aw_hit  = (s_axi_awaddr[ADDR_W-1:2] == CTL_OFF[ADDR_W-1:2]);
      end
      // Capture low byte of write data
      if (w_fire) begin
         d.w_have  = 1'b1;
         d.w_data  = s_axi_wdata[7:0]; // R12
         d.w_lane0 = s_axi_wstrb[0];
      end
      // Apply the write once both halves are in
      if (commit) begin
         d.aw_have = 1'b0;
         d.w_have  = 1'b0;
         d.bvalid  = 1'b1;
         d.bresp   = q.aw_hit ? `RESP_OKAY : `RESP_SLVERR;
         if (q.aw_hit && q.w_lane0) begin
            if (!q.host_en) begin
               d.pkt_dis = q.w_data[`BIT_PKT_TOK]; // R3
            end
            d.bus_rst   = q.w_data[`BIT_BUS_RST]; // R6
            d.host_en   = q.w_data[`BIT_HOST_EN]; // R7
            d.resume_en = q.w_data[`BIT_RESUME]; // R9
            d.ppb_rst   = q.w_data[`BIT_PPB_RST];
            d.usb_en    = q.w_data[`BIT_USB_EN];
         end
      end
      // SETUP token sets the disable, winning over a clear
      if (setup_token_rcvd && !q.host_en) begin
         d.pkt_dis = 1'b1; // R3
      end
      // Write response retires
      if (q.bvalid && s_axi_bready) begin
         d.bvalid = 1'b0;
      end
      // Read response retires
      if (q.rvalid && s_axi_rready) begin
         d.rvalid = 1'b0;
      end
      // Read takes a snapshot of the live word
      if (ar_fire) begin
         d.rvalid = 1'b1;
         d.rresp  = ar_hit ? `RESP_OKAY : `RESP_SLVERR;
         d.rdata  = ar_hit ? {24'h00_0000, ctl_word} : 32'h0000_0000; // R12
      end
   end

   // State register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // ----------------------------------------------------------------
   // Host enable change detection
   // ----------------------------------------------------------------
   change_detect #(
      .W (1)
   ) u_host_toggle (
      .aclk    (aclk),
      .aresetn (aresetn),
      .level   (q.host_en),
      .changed (host_toggle)
   );

   // ----------------------------------------------------------------
   // Resume engine
   // ----------------------------------------------------------------
   assign rif.resume_en = q.resume_en;
   assign rif.host_mode = q.host_en;
   assign rif.abort     = host_toggle; // R8

   resume_engine #(
      .EOP_CYCLES (EOP_CYCLES)
   ) u_resume (
      .aclk    (aclk),
      .aresetn (aresetn),
      .rif     (rif)
   );

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------

   // Bus side
   assign s_axi_bvalid = q.bvalid;
   assign s_axi_bresp  = q.bresp;
   assign s_axi_rvalid = q.rvalid;
   assign s_axi_rdata  = q.rdata;
   assign s_axi_rresp  = q.rresp;

   // Engine controls
   assign packet_processing_disable = q.pkt_dis && !q.host_en; // R3
   assign host_capability_enable    = q.host_en; // R7
   assign host_logic_reset          = host_toggle; // R8
   assign bus_reset_generate        = q.bus_rst && q.host_en && !host_toggle; // R6
   assign ping_pong_reset           = q.ppb_rst;
   assign module_enable             = q.usb_en;
   assign resume_drive              = rif.resume_drive; // R9
   assign eop_drive                 = rif.eop_drive; // R11

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   // Committed write to the control word
   sequence s_ctl_write;
      commit && q.aw_hit && q.w_lane0;
   endsequence

   // Read of the control word accepted
   sequence s_ctl_read;
      ar_fire && ar_hit;
   endsequence

   // Resume released while signalling
   sequence s_resume_release;
      resume_drive && !q.resume_en && !host_toggle;
   endsequence

   a_live_j_read: assert property (s_ctl_read |=> s_axi_rvalid && s_axi_rdata[7] == $past(rx_j_state)) // R1
      else $error("J state flag read wrong");

   a_live_se0_read: assert property (s_ctl_read |=> s_axi_rdata[6] == $past(rx_se0)) // R2
      else $error("SE0 flag read wrong");

   a_setup_sets_disable: assert property (
      setup_token_rcvd && !q.host_en && !(commit && q.aw_hit && q.w_lane0 && q.w_data[3])
      |=> packet_processing_disable) // R3
      else $error("SETUP token did not set packet disable");

   a_token_busy_read: assert property ((s_ctl_read and q.host_en) |=> s_axi_rdata[5] == $past(token_active)) // R4
      else $error("Token busy flag read wrong");

   a_bus_reset_write: assert property (
      (s_ctl_write and (q.host_en && !host_toggle && q.w_data[4] && q.w_data[3])) |=> bus_reset_generate) // R6
      else $error("Bus reset not generated after write");

   a_bus_reset_stop: assert property ((s_ctl_write and !q.w_data[4]) |=> !bus_reset_generate) // R6
      else $error("Bus reset not terminated after write");

   a_host_enable_write: assert property (s_ctl_write |=> host_capability_enable == $past(q.w_data[3])) // R7
      else $error("Host enable does not follow write");

   a_host_toggle_reset: assert property ($changed(host_capability_enable) |-> host_logic_reset ##1 !eop_drive) // R8
      else $error("Host enable change did not reset host logic");

   a_resume_follows: assert property (
      q.resume_en && !host_toggle ##1 q.resume_en && !host_toggle |-> resume_drive) // R9
      else $error("Resume not driven while enabled");

   a_resume_device_stop: assert property ((s_resume_release and !q.host_en) |=> !resume_drive && !eop_drive) // R9
      else $error("Device resume did not stop cleanly");

   a_resume_eop_append: assert property (
      (s_resume_release and q.host_en) |=> eop_drive ##1 (eop_drive || q.resume_en || host_toggle)) // R11
      else $error("Low-speed EOP not appended");

   a_eop_bounded: assert property ($rose(eop_drive) |-> ##[1:400] !eop_drive) // R11
      else $error("EOP lasted too long");

   a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000) // R12
      else $error("Unimplemented bits read non-zero");

   // Write response holds until taken
   a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("Write response dropped early");

   // Read response holds until taken
   a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("Read response dropped early");

   // Every committed write is answered
   a_write_answer: assert property (commit |=> s_axi_bvalid)
      else $error("Write not answered");

   // Unmapped read answers error and zero
   a_unmapped_read: assert property (ar_fire && !ar_hit |=> s_axi_rresp == `RESP_SLVERR && s_axi_rdata == '0)
      else $error("Unmapped read answered wrongly");

   // Write without lane 0 changes nothing
   a_lane_ignored: assert property (commit && !q.w_lane0 |=> $stable(host_capability_enable) && $stable(q.resume_en))
      else $error("Write without lane 0 changed state");

   // SETUP beats a clear written in the same cycle
   a_setup_over_clear: assert property (setup_token_rcvd && !q.host_en |=> q.pkt_dis) // R3
      else $error("Clear won over SETUP");

   // Host mode leaves the stored disable alone
   a_host_keeps_disable: assert property (q.host_en |=> $stable(q.pkt_dis)) // R4
      else $error("Stored disable changed in host mode");

   // Host logic reset is a single pulse
   a_host_reset_pulse: assert property (host_logic_reset |=> !host_logic_reset) // R8
      else $error("Host logic reset longer than one cycle");

   // Bus reset keeps going until rewritten
   a_bus_reset_hold: assert property (bus_reset_generate && !commit |=> bus_reset_generate) // R6
      else $error("Bus reset dropped without a write");

   // Setting resume starts signalling next cycle
   a_resume_start: assert property ($rose(q.resume_en) && !host_toggle |=> resume_drive) // R9
      else $error("Resume not started");

   // EOP only follows host-mode signalling
   a_eop_from_host: assert property ($rose(eop_drive) |-> $past(host_capability_enable)) // R11
      else $error("EOP started outside host mode");

   // Device mode never starts an EOP
   a_device_no_eop: assert property (!q.host_en && !eop_drive |=> !eop_drive) // R11
      else $error("EOP started in device mode");

endmodule

`default_nettype wire

// file: tb/usb_bus_model.sv
`timescale 1ns/10ps
`default_nettype none

// Far side of the link: line states as seen by the receiver, plus engine status
module usb_bus_model (
   // Clock and reset
   input  wire logic       aclk,
   input  wire logic       aresetn,
   // Signalling driven by the module
   input  wire logic       resume_drive,
   input  wire logic       eop_drive,
   input  wire logic       bus_reset_generate,
   input  wire logic       host_mode,
   // Requests from the bench
   input  wire logic       setup_req,
   input  wire logic       token_req,
   input  wire logic [7:0] tok_len,
   // Receiver and engine status
   output logic            rx_j_state,
   output logic            rx_se0,
   output logic            setup_token_rcvd,
   output logic            token_active
);
   logic [7:0] tok_cnt_q;

   // Reset and EOP pull both lines low, resume drives K, otherwise idle J
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_j_state       <= 1'b1;
         rx_se0           <= 1'b0;
         setup_token_rcvd <= 1'b0;
         tok_cnt_q        <= 8'h00;
      end else begin
         rx_se0           <= bus_reset_generate | eop_drive;
         rx_j_state       <= ~(bus_reset_generate | eop_drive | resume_drive);
         setup_token_rcvd <= setup_req & ~host_mode;
         if (token_req && host_mode) begin
            tok_cnt_q <= tok_len; // Token lasts a bench-chosen time
         end else if (tok_cnt_q != 8'h00) begin
            tok_cnt_q <= tok_cnt_q - 8'h01;
         end
      end
   end

   // Token in flight while the count runs
   assign token_active = (tok_cnt_q != 8'h00);
endmodule

`default_nettype wire

// file: tb/tb.sv
`timescale 1ns/10ps
`default_nettype none

`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
   $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end

module tb;
   localparam int EOP = 4;
   logic        aclk, aresetn;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata, d, got;
   logic [3:0]  wstrb, s;
   logic [1:0]  bresp, rresp, r;
   logic        j, se0, setup_p, tok_act, setup_req, token_req;
   logic [7:0]  tok_len;
   logic        pkt_dis, host_en, host_rst, bus_rst, ppb, usb_en, res_drv, eop_drv;
   logic [5:0]  st;
   int          miscompares, n_compared, host_pulses, hp, eop_len, seed, n;

   // ----------------------------------------------------------------
   // Clock, design and far side
   // ----------------------------------------------------------------
   initial begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end

   usb_control_register #(.ADDR_W(12), .EOP_CYCLES(EOP)) DUT (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .rx_j_state(j), .rx_se0(se0), .setup_token_rcvd(setup_p), .token_active(tok_act),
      .packet_processing_disable(pkt_dis), .host_capability_enable(host_en),
      .host_logic_reset(host_rst), .bus_reset_generate(bus_rst), .ping_pong_reset(ppb),
      .module_enable(usb_en), .resume_drive(res_drv), .eop_drive(eop_drv));

   usb_bus_model far_end (
      .aclk(aclk), .aresetn(aresetn), .resume_drive(res_drv), .eop_drive(eop_drv),
      .bus_reset_generate(bus_rst), .host_mode(host_en), .setup_req(setup_req),
      .token_req(token_req), .tok_len(tok_len), .rx_j_state(j), .rx_se0(se0),
      .setup_token_rcvd(setup_p), .token_active(tok_act));

   // Counts host reset pulses and EOP length
   always @(negedge aclk) begin
      if (host_rst === 1'b1) host_pulses++;
      if (eop_drv === 1'b1) eop_len++;
   end

   // ----------------------------------------------------------------
   // Bench tasks
   // ----------------------------------------------------------------
   task automatic end_of_test;
      if (miscompares == 0 && n_compared > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   task automatic timeout;
      miscompares++;
      end_of_test;
   endtask

   // Write: address and data offered together, each released once taken
   task automatic wr(input logic [11:0] a, input logic [31:0] dd, input logic [3:0] ss,
                     output logic [1:0] rs);
      bit aw, w, b;
      int k;
      b = 0;
      k = 0;
      rs = 2'b11;
      @(posedge aclk);
      awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= dd; wstrb <= ss; bready <= 1'b1;
      while (!b && k < 50) begin
         @(negedge aclk);
         aw = awvalid && awready;
         w = wvalid && wready;
         b = bvalid;
         if (b) rs = bresp;
         @(posedge aclk);
         k++;
         if (aw) awvalid <= 1'b0;
         if (w) wvalid <= 1'b0;
         if (b) bready <= 1'b0;
      end
      if (!b) timeout;
   endtask

   task automatic rd(input logic [11:0] a, output logic [31:0] dd, output logic [1:0] rs);
      bit ar, v;
      int k;
      v = 0;
      k = 0;
      @(posedge aclk);
      arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
      while (!v && k < 50) begin
         @(negedge aclk);
         ar = arvalid && arready;
         v = rvalid;
         if (v) begin
            dd = rdata;
            rs = rresp;
         end
         @(posedge aclk);
         k++;
         if (ar) arvalid <= 1'b0;
         if (v) rready <= 1'b0;
      end
      if (!v) timeout;
   endtask

   task automatic wait_until(ref logic sig, input logic v);
      int k;
      for (k = 0; k < 1000 && sig !== v; k++) @(negedge aclk);
      if (sig !== v) timeout;
   endtask

   // One-cycle request to the far side: SETUP when tok is 0, token when 1
   task automatic pulse(input bit tok);
      @(posedge aclk);
      if (tok) token_req <= 1'b1;
      else setup_req <= 1'b1;
      @(posedge aclk);
      token_req <= 1'b0;
      setup_req <= 1'b0;
      repeat (3) @(negedge aclk);
   endtask

   // Expected register word from stored bits and live line state
   function automatic logic [31:0] exp_word(logic [5:0] sb, logic jj, logic zz, logic tk);
      return {24'h000000, jj, zz, (sb[3] ? tk : sb[5]), sb[4:0]};
   endfunction

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
      awaddr = 12'h000; araddr = 12'h000; wdata = 32'h0; wstrb = 4'h0;
      setup_req = 1'b0; token_req = 1'b0; tok_len = 8'h05;
      miscompares = 0; n_compared = 0; host_pulses = 0; eop_len = 0; st = 6'h00;
      seed = $urandom(87);
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      rd(12'h000, got, r);
      `CHK(got, 32'h00000080)
      rd(12'h004, got, r);
      `CHK({r, got}, {2'b10, 32'h0})
      wr(12'hffc, 32'hffffffff, 4'hf, r);
      `CHK(r, 2'b10)
      // Random writes, resume and bus reset kept off so the line stays idle
      repeat (40) begin
         d = $urandom & ~32'h00000014;
         s = 4'($urandom);
         if (st[3] | d[3]) d[5] = st[5];
         hp = host_pulses;
         wr(12'h000, d, s, r);
         `CHK(r, 2'b00)
         if (s[0]) begin
            if (st[3] != d[3]) hp++;
            st = d[5:0];
         end
         repeat (2) @(negedge aclk);
         `CHK(host_en, st[3])
         `CHK(pkt_dis, st[5] & ~st[3])
         `CHK(host_pulses, hp)
         `CHK({ppb, usb_en}, st[1:0])
         rd(12'h000, got, r);
         `CHK(got, exp_word(st, 1'b1, 1'b0, 1'b0))
      end
      // SETUP token in device mode sets the disable bit
      wr(12'h000, 32'h0, 4'h1, r);
      pulse(1'b0);
      `CHK(pkt_dis, 1'b1)
      rd(12'h000, got, r);
      `CHK(got, 32'h000000a0)
      wr(12'h000, 32'h0, 4'h1, r);
      rd(12'h000, got, r);
      `CHK(got, 32'h00000080)
      // Host token busy, polled until clear before the next token
      wr(12'h000, 32'h08, 4'h1, r);
      tok_len = 8'(20 + $urandom % 20);
      pulse(1'b1);
      rd(12'h000, got, r);
      `CHK(got, 32'h000000a8)
      n = 0;
      while (got[5] === 1'b1 && n < 100) begin
         rd(12'h000, got, r);
         n++;
      end
      `CHK(got, 32'h00000088)
      // Bus reset drives SE0 on the line
      wr(12'h000, 32'h18, 4'h1, r);
      wait_until(bus_rst, 1'b1);
      repeat (3) @(negedge aclk);
      rd(12'h000, got, r);
      `CHK(got, 32'h00000058)
      wr(12'h000, 32'h08, 4'h1, r);
      @(negedge aclk);
      `CHK(bus_rst, 1'b0)
      // Host resume ends with a low-speed EOP of fixed length
      wr(12'h000, 32'h0c, 4'h1, r);
      wait_until(res_drv, 1'b1);
      repeat (3) @(negedge aclk);
      rd(12'h000, got, r);
      `CHK(got, 32'h0000000c)
      repeat (20) @(negedge aclk);
      eop_len = 0;
      wr(12'h000, 32'h08, 4'h1, r);
      wait_until(eop_drv, 1'b1);
      wait_until(eop_drv, 1'b0);
      `CHK(res_drv, 1'b0)
      `CHK(eop_len, EOP)
      // Device resume stops with no EOP
      wr(12'h000, 32'h04, 4'h1, r);
      wait_until(res_drv, 1'b1);
      eop_len = 0;
      wr(12'h000, 32'h00, 4'h1, r);
      repeat (EOP + 4) @(negedge aclk);
      `CHK({res_drv, eop_drv}, 2'b00)
      `CHK(eop_len, 0)
      end_of_test;
   end
endmodule

`default_nettype wire
